// >>> spi_cfg_defs.svh
// constants shared by both ends of the configuration port
`ifndef SPI_CFG_DEFS_SVH
`define SPI_CFG_DEFS_SVH
`define CLK_PERIOD_NS   5
`define SCLK_HALF_NS    25
`define SCLK_HALF_CYC   ((`SCLK_HALF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_INIT_NS    40
`define SYNC_INIT_CYC   ((`SYNC_INIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REG_RESET       8'h00
`define ADDR_LIMIT      7'h78
`define REG_PULSE_CFG   7'h1c
`define PULSE_SRC_BIT   0
`define PULSE_MODE_BIT  1
`define REG_PULSE_START 7'h70
`define PULSE_START_BIT 0
`define REG_GEN_CTRL    7'h71
`define SYNC_TRIG_BIT   0
`define PLL_REACQUIRE_TRIGGER_BIT      1
`define EDGE_SEL_BIT    2
`define M_REG_CMD       2'h0
`define M_REG_TX        2'h1
`define M_REG_RX        2'h2
`define M_REG_STAT      2'h3
`define CMD_READ_BIT    7
`define CMD_CNT_LSB     8
`define CMD_CNT_MSB     14
`endif

// >>> spi_cfg_pkg.sv
// types shared by both ends of the configuration port
package spi_cfg_pkg;
  typedef enum logic [1:0] {PH_CMD = 2'b00, PH_WR = 2'b01, PH_RD = 2'b10} phase_t;
  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_LEAD = 3'b001,
    M_LOW  = 3'b010,
    M_HIGH = 3'b011,
    M_NEXT = 3'b100,
    M_TAIL = 3'b101
  } mstate_t;
endpackage : spi_cfg_pkg

// >>> spi_cfg_if.sv
// serial link between the configuration master and the device port
`timescale 1ns/1ps
`default_nettype none
interface spi_cfg_if;
  logic sclk;
  logic port_select_n;
  logic m_sdo;
  logic m_oe_n;
  logic d_sdo;
  logic d_oe_n;
  wire  serial_io_line;
  // pull-up when nobody drives the shared line
  assign serial_io_line = !d_oe_n ? d_sdo : (!m_oe_n ? m_sdo : 1'b1);
  modport dev (input sclk, input port_select_n, input serial_io_line,
               output d_sdo, output d_oe_n);
  modport mst (output sclk, output port_select_n, input serial_io_line,
               output m_sdo, output m_oe_n);
endinterface : spi_cfg_if
`default_nettype wire

// >>> spi_cfg_master.sv
// serial master: issues command byte and payload bytes from a host port
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg_defs.svh"
module spi_cfg_master (
  // clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_in,
  // serial link
  spi_cfg_if.mst           link,
  // host port
  input  wire logic [1:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out
);
  import spi_cfg_pkg::*;
  localparam logic [2:0] HALF = 3'(`SCLK_HALF_CYC);

  spi_cfg_pkg::mstate_t st_q;
  logic [2:0] div_q;
  logic       tick;
  logic       sclk_q, cs_n_q, sdo_q, oe_n_q;
  logic [7:0] sh_q, rx_sh_q, rx_q, tx_q;
  logic [2:0] bit_q;
  logic [6:0] left_q;
  logic       rd_q, ph_cmd_q, tx_full_q, rx_valid_q;
  logic       start, busy, rx_done, load;

  assign tick = (div_q == HALF - 3'h1);
  assign busy = (st_q != M_IDLE);
  assign start = wr_in && addr_in == `M_REG_CMD && !busy
                 && wdata_in[`CMD_CNT_MSB:`CMD_CNT_LSB] != 7'h00;
  assign rx_done = st_q == M_LOW && tick && bit_q == 3'h7 && !ph_cmd_q && rd_q;
  // stall between bytes until the host has supplied or collected data
  assign load = st_q == M_NEXT && (rd_q ? !rx_valid_q : tx_full_q);

  assign link.sclk          = sclk_q;
  assign link.port_select_n = cs_n_q;
  assign link.m_sdo         = sdo_q;
  assign link.m_oe_n        = oe_n_q;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      div_q <= 3'h0;
    // restart on a stall release so the low half keeps its full length
    else if (!busy || tick || load)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= M_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
      sh_q <= 8'h00;
      rx_sh_q <= 8'h00;
      bit_q <= 3'h0;
      left_q <= 7'h00;
      rd_q <= 1'b0;
      ph_cmd_q <= 1'b0;
    end
    else
    begin
      case (st_q)
        M_IDLE:
          if (start)
          begin
            // direction bit first, then address LSB first
            rd_q <= wdata_in[`CMD_READ_BIT];
            sh_q <= {wdata_in[6:0], wdata_in[`CMD_READ_BIT]};
            sdo_q <= wdata_in[`CMD_READ_BIT];
            left_q <= wdata_in[`CMD_CNT_MSB:`CMD_CNT_LSB];
            ph_cmd_q <= 1'b1;
            cs_n_q <= 1'b0;
            oe_n_q <= 1'b0;
            bit_q <= 3'h0;
            st_q <= M_LEAD;
          end
        M_LEAD:
          if (tick)
            st_q <= M_LOW;
        M_LOW:
          if (tick)
          begin
            sclk_q <= 1'b1;
            bit_q <= bit_q + 3'h1;
            rx_sh_q <= {link.serial_io_line, rx_sh_q[7:1]};
            st_q <= M_HIGH;
          end
        M_HIGH:
        begin
          // let go one cycle after the 8th rise: the device samples A6 there
          if (bit_q == 3'h0 && ph_cmd_q && rd_q)
            oe_n_q <= 1'b1;
          if (tick)
          begin
            sclk_q <= 1'b0;
            if (bit_q == 3'h0)
            begin
              ph_cmd_q <= 1'b0;
              // select only ever released on a byte boundary
              st_q <= (left_q == 7'h00) ? M_TAIL : M_NEXT;
            end
            else
            begin
              sdo_q <= sh_q[bit_q];
              st_q <= M_LOW;
            end
          end
        end
        M_NEXT:
          if (load)
          begin
            left_q <= left_q - 7'h01;
            if (!rd_q)
            begin
              sh_q <= tx_q;
              sdo_q <= tx_q[0];
            end
            st_q <= M_LOW;
          end
        M_TAIL:
          if (tick)
          begin
            cs_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            st_q <= M_IDLE;
          end
        default:
          st_q <= M_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_q <= 8'h00;
      tx_full_q <= 1'b0;
    end
    else if (wr_in && addr_in == `M_REG_TX)
    begin
      tx_q <= wdata_in[7:0];
      tx_full_q <= 1'b1;
    end
    else if (load && !rd_q)
      tx_full_q <= 1'b0;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_q <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else if (rx_done)
    begin
      rx_q <= {link.serial_io_line, rx_sh_q[7:1]};
      rx_valid_q <= 1'b1;
    end
    else if (rd_in && addr_in == `M_REG_RX)
      rx_valid_q <= 1'b0;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= 16'h0000;
    else if (!rd_in)
      rdata_out <= 16'h0000;
    else if (addr_in == `M_REG_RX)
      rdata_out <= {8'h00, rx_q};
    else if (addr_in == `M_REG_STAT)
      rdata_out <= {13'h0000, rx_valid_q, tx_full_q, busy};
    else if (addr_in == `M_REG_TX)
      rdata_out <= {8'h00, tx_q};
    else
      rdata_out <= 16'h0000;
  end
endmodule : spi_cfg_master
`default_nettype wire

// >>> spi_cfg_device.sv
// device end: serial slave, register bank and divider/pulse triggers
`timescale 1ns/1ps
`default_nettype none
`include "spi_cfg_defs.svh"
module spi_cfg_device (
  // clock and reset
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  // serial link
  spi_cfg_if.dev          link,
  // user side
  input  wire logic       external_trigger_in,
  input  wire logic [7:0] clock_src_in,
  input  wire logic [3:0] frame_src_in,
  output logic      [7:0] clock_outputs_out,
  output logic      [3:0] frame_ref_outputs_out,
  output logic            divider_sync_out,
  output logic            pll_reacquire_trigger_out,
  output logic            pulse_fire_out,
  output logic            pulse_count_mode_out,
  output logic            read_edge_select_out
);
  import spi_cfg_pkg::*;
  localparam int unsigned NREG = 128;
  localparam logic [3:0] INIT_CYC = 4'(`SYNC_INIT_CYC);

  logic [7:0] regs_q [0:NREG-1];
  spi_cfg_pkg::phase_t phase_q;
  logic       sclk_prev_q, ext_prev_q;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, tx_q, rx_byte, tx_d;
  logic [6:0] addr_q, rd_addr;
  logic       sdo_q, oe_n_q;
  logic       active, rise, fall, byte_end, wr_en, edge_sel;
  logic [3:0] init_cnt_q, init_cnt_d;
  logic       sync_clr, pll_reacquire_trigger_bit, start_bit, fire;
  logic [7:0] gen_clr, start_clr;

  // unmapped upper addresses read back as zero
  function automatic logic [7:0] reg_read(input logic [6:0] a);
    reg_read = (a < `ADDR_LIMIT) ? regs_q[a] : 8'h00;
  endfunction : reg_read

  assign active   = !link.port_select_n;
  assign rise     = active && link.sclk && !sclk_prev_q;
  assign fall     = active && !link.sclk && sclk_prev_q;
  assign rx_byte  = {link.serial_io_line, sh_q[7:1]};
  assign cnt_d    = cnt_q + 3'h1;
  assign byte_end = rise && cnt_q == 3'h7;
  assign rd_addr  = (phase_q == PH_CMD) ? rx_byte[7:1] : addr_q + 7'h01;
  assign tx_d     = reg_read(rd_addr);
  // writes at or above the limit are dropped rather than aliased
  assign wr_en    = byte_end && phase_q == PH_WR && addr_q < `ADDR_LIMIT;
  assign edge_sel = regs_q[`REG_GEN_CTRL][`EDGE_SEL_BIT];

  assign link.d_sdo  = sdo_q;
  assign link.d_oe_n = oe_n_q;

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= link.sclk;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q <= PH_CMD;
      cnt_q <= 3'h0;
      sh_q <= 8'h00;
      addr_q <= 7'h00;
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      oe_n_q <= 1'b1;
    end
    else if (!active)
    begin
      // next frame starts with a fresh command byte
      phase_q <= PH_CMD;
      cnt_q <= 3'h0;
      oe_n_q <= 1'b1;
    end
    else if (rise)
    begin
      cnt_q <= cnt_d;
      sh_q <= rx_byte;
      if (byte_end)
      begin
        if (phase_q == PH_CMD)
        begin
          addr_q <= rx_byte[7:1];
          phase_q <= rx_byte[0] ? PH_RD : PH_WR;
        end
        else
          addr_q <= addr_q + 7'h01;
        if (phase_q == PH_RD || (phase_q == PH_CMD && rx_byte[0]))
        begin
          // address wraps, so block reads of any length keep going
          tx_q <= tx_d;
          oe_n_q <= 1'b0;
          if (phase_q == PH_CMD || edge_sel)
            sdo_q <= tx_d[0];
        end
      end
      else if (phase_q == PH_RD && edge_sel)
        sdo_q <= tx_q[cnt_d];
    end
    else if (fall && phase_q == PH_RD && !edge_sel)
      sdo_q <= tx_q[cnt_q];
  end

  // hardware clears of self-clearing bits
  assign pll_reacquire_trigger_bit = regs_q[`REG_GEN_CTRL][`PLL_REACQUIRE_TRIGGER_BIT];
  assign start_bit  = regs_q[`REG_PULSE_START][`PULSE_START_BIT];
  assign sync_clr   = (init_cnt_q == 4'h1);
  assign fire       = start_bit && (!regs_q[`REG_PULSE_CFG][`PULSE_SRC_BIT]
                      || (external_trigger_in && !ext_prev_q));

  always_comb
  begin
    gen_clr = 8'h00;
    gen_clr[`SYNC_TRIG_BIT] = sync_clr;
    gen_clr[`PLL_REACQUIRE_TRIGGER_BIT] = pll_reacquire_trigger_bit;
    start_clr = 8'h00;
    start_clr[`PULSE_START_BIT] = fire;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++)
    begin : g_reg
      logic [7:0] clr_w;
      assign clr_w = (gi == `REG_GEN_CTRL) ? gen_clr
                   : ((gi == `REG_PULSE_START) ? start_clr : 8'h00);
      // a new write beats a same-cycle hardware clear
      always_ff @(posedge clock_in or posedge rst_in)
      begin
        if (rst_in)
          regs_q[gi] <= `REG_RESET;
        else if (wr_en && addr_q == 7'(gi))
          regs_q[gi] <= rx_byte;
        else
          regs_q[gi] <= regs_q[gi] & ~clr_w;
      end
    end
  endgenerate

  always_comb
  begin
    if (init_cnt_q != 4'h0)
      init_cnt_d = init_cnt_q - 4'h1;
    else if (regs_q[`REG_GEN_CTRL][`SYNC_TRIG_BIT])
      init_cnt_d = INIT_CYC;
    else
      init_cnt_d = 4'h0;
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      init_cnt_q <= 4'h0;
      ext_prev_q <= 1'b0;
    end
    else
    begin
      init_cnt_q <= init_cnt_d;
      ext_prev_q <= external_trigger_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      clock_outputs_out <= 8'h00;
      frame_ref_outputs_out <= 4'h0;
      divider_sync_out <= 1'b0;
    end
    else
    begin
      divider_sync_out <= (init_cnt_d != 4'h0);
      clock_outputs_out <= (init_cnt_d != 4'h0) ? 8'h00 : clock_src_in;
      frame_ref_outputs_out <= (init_cnt_d != 4'h0) ? 4'h0 : frame_src_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pll_reacquire_trigger_out <= 1'b0;
      pulse_fire_out <= 1'b0;
      pulse_count_mode_out <= 1'b0;
      read_edge_select_out <= 1'b0;
    end
    else
    begin
      pll_reacquire_trigger_out <= pll_reacquire_trigger_bit;
      pulse_fire_out <= fire;
      pulse_count_mode_out <= regs_q[`REG_PULSE_CFG][`PULSE_MODE_BIT];
      read_edge_select_out <= edge_sel;
    end
  end
endmodule : spi_cfg_device
`default_nettype wire

// >>> spi_cfg_monitor.sv
// concurrent checks on the serial link and the device outputs
`timescale 1ns/1ps
`default_nettype none
module spi_cfg_monitor (
  // clock and reset
  input wire logic       clock_in,
  input wire logic       rst_in,
  // serial link
  input wire logic       sclk,
  input wire logic       port_select_n,
  input wire logic       d_sdo,
  input wire logic       d_oe_n,
  // device outputs
  input wire logic [7:0] clock_outputs_out,
  input wire logic [3:0] frame_ref_outputs_out,
  input wire logic       divider_sync_out,
  input wire logic       pll_reacquire_trigger_out,
  input wire logic       pulse_fire_out,
  input wire logic       read_edge_select_out
);
  logic [3:0] sclk_q;
  logic [3:0] rises_q;
  logic       rise_w;
  logic       fall_w;
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      sclk_q <= 4'h0;
    else
      sclk_q <= {sclk_q[2:0], sclk};
  // saturates so a long block read never wraps back to 8
  always_ff @(posedge clock_in or posedge rst_in)
    if (rst_in)
      rises_q <= 4'h0;
    else if (port_select_n)
      rises_q <= 4'h0;
    else if (sclk && !sclk_q[0] && rises_q != 4'hf)
      rises_q <= rises_q + 4'h1;
  // a few cycles of slack for the device's input sampling
  assign rise_w = |({sclk, sclk_q[2:0]} & ~sclk_q);
  assign fall_w = |(~{sclk, sclk_q[2:0]} & sclk_q);
  default clocking @(posedge clock_in); endclocking
  default disable iff (rst_in);
  sequence sync_window;
    divider_sync_out [*8] ##1 !divider_sync_out;
  endsequence
  a_idle_released: assert property (port_select_n && $past(port_select_n) |-> d_oe_n)
    else $error("line driven while deselected");
  a_start_input: assert property ($fell(port_select_n) |-> d_oe_n [*8])
    else $error("line not input at frame start");
  a_clock_framed: assert property ($rose(sclk) |-> !port_select_n)
    else $error("serial clock outside a frame");
  a_turn_after_cmd: assert property ($fell(d_oe_n) |-> rises_q == 4'h8)
    else $error("line turned at wrong bit count");
  a_read_edge: assert property (!d_oe_n && $past(!d_oe_n) && $changed(d_sdo)
    |-> (read_edge_select_out ? rise_w : fall_w))
    else $error("read data changed on wrong edge");
  a_sync_window: assert property ($rose(divider_sync_out) |-> sync_window)
    else $error("init window not eight cycles");
  a_outputs_low: assert property (divider_sync_out
    |-> clock_outputs_out == 8'h00 && frame_ref_outputs_out == 4'h0)
    else $error("outputs not low during init");
  a_pll_reacquire_trigger_single: assert property (pll_reacquire_trigger_out |=> !pll_reacquire_trigger_out)
    else $error("pll_reacquire_trigger pulse too long");
  a_fire_single: assert property (pulse_fire_out |=> !pulse_fire_out)
    else $error("fire pulse too long");
  a_release_end: assert property ($rose(port_select_n) |-> ##[1:2] d_oe_n)
    else $error("line not released after frame");
endmodule : spi_cfg_monitor
`default_nettype wire

// >>> tb.sv
// self-checking bench: master and device joined over the serial link
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clock_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [1:0]  addr = 2'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr_s = 1'b0;
  logic        rd_s = 1'b0;
  logic        ext_trig = 1'b0;
  logic [15:0] rdata;
  logic [15:0] got;
  logic [7:0]  clk_out;
  logic [3:0]  frm_out;
  logic        sync_o, pll_reacquire_trigger_o, fire_o, mode_o, edge_o;
  int          err_total = 0;
  int          compares = 0;
  int          cyc = 0, sync_n = 0, pll_reacquire_trigger_n = 0, fire_n = 0;
  spi_cfg_if link_if ();
  spi_cfg_master spi_cfg_master_i (
    .clock_in (clock_in), .rst_in (rst_in), .link (link_if.mst),
    .addr_in (addr), .wdata_in (wdata), .wr_in (wr_s), .rd_in (rd_s),
    .rdata_out (rdata)
  );
  spi_cfg_device spi_cfg_device_i (
    .clock_in (clock_in), .rst_in (rst_in), .link (link_if.dev),
    .external_trigger_in (ext_trig), .clock_src_in (8'hff), .frame_src_in (4'hf),
    .clock_outputs_out (clk_out), .frame_ref_outputs_out (frm_out),
    .divider_sync_out (sync_o), .pll_reacquire_trigger_out (pll_reacquire_trigger_o),
    .pulse_fire_out (fire_o), .pulse_count_mode_out (mode_o),
    .read_edge_select_out (edge_o)
  );
  spi_cfg_monitor spi_cfg_monitor_i (
    .clock_in (clock_in), .rst_in (rst_in), .sclk (link_if.sclk),
    .port_select_n (link_if.port_select_n), .d_sdo (link_if.d_sdo),
    .d_oe_n (link_if.d_oe_n), .clock_outputs_out (clk_out),
    .frame_ref_outputs_out (frm_out), .divider_sync_out (sync_o),
    .pll_reacquire_trigger_out (pll_reacquire_trigger_o), .pulse_fire_out (fire_o),
    .read_edge_select_out (edge_o)
  );
  always #2.5 clock_in = ~clock_in;
  task automatic close_out();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // pulse counters and a cycle ceiling well above the ~3.5k cycles used
  always @(posedge clock_in)
  begin
    cyc <= cyc + 1;
    sync_n <= sync_n + int'(sync_o);
    pll_reacquire_trigger_n <= pll_reacquire_trigger_n + int'(pll_reacquire_trigger_o);
    fire_n <= fire_n + int'(fire_o);
    if (cyc == 40000)
    begin
      err_total++;
      close_out();
    end
  end
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk8
  task automatic chk1(input string nm, input logic e, input logic g);
    chk8(nm, {7'h00, e}, {7'h00, g});
  endtask : chk1
  task automatic hw(input logic [1:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clock_in);
    wr_s <= 1'b0;
    @(posedge clock_in);
  endtask : hw
  task automatic hr(input logic [1:0] a);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_in);
    rd_s <= 1'b0;
    // data stand in the cycle after the strobe; take them at its closing edge
    @(posedge clock_in);
    got = rdata;
  endtask : hr
  // polls status; a hang is caught by the cycle ceiling
  task automatic wait_st(input int b, input logic v);
    do
      hr(2'h3);
    while (got[b] !== v);
  endtask : wait_st
  task automatic dev_wr(input logic [6:0] a, input logic [6:0] n, input logic [7:0] d);
    hw(2'h1, {8'h00, d});
    hw(2'h0, {1'b0, n, 1'b0, a});
    for (int i = 1; i < n; i++)
    begin
      wait_st(1, 1'b0);
      hw(2'h1, {8'h00, d + 8'(i * 17)});
    end
    wait_st(0, 1'b0);
  endtask : dev_wr
  task automatic dev_rd(input logic [6:0] a, input logic [6:0] n, input logic [7:0] d);
    hw(2'h0, {1'b0, n, 1'b1, a});
    for (int i = 0; i < n; i++)
    begin
      wait_st(2, 1'b1);
      hr(2'h2);
      chk8("read byte", d + 8'(i * 17), got[7:0]);
    end
    wait_st(0, 1'b0);
  endtask : dev_rd
  initial
  begin
    repeat (5) @(posedge clock_in);
    rst_in <= 1'b0;
    @(posedge clock_in);
    dev_wr(7'h10, 7'd4, 8'h21);
    dev_rd(7'h10, 7'd4, 8'h21);
    // highest usable register; the range from 0x78 up is never touched
    dev_wr(7'h77, 7'd1, 8'h5a);
    dev_rd(7'h77, 7'd1, 8'h5a);
    $display("test block access done");
    dev_wr(7'h71, 7'd1, 8'h04);
    chk1("edge select", 1'b1, edge_o);
    dev_rd(7'h11, 7'd2, 8'h32);
    $display("test read edge done");
    dev_wr(7'h20, 7'd1, 8'h07);
    dev_wr(7'h71, 7'd1, 8'h05);
    chk8("sync cycles", 8'h08, 8'(sync_n));
    chk8("clock outputs", 8'hff, clk_out);
    chk8("frame outputs", 8'h0f, {4'h0, frm_out});
    dev_rd(7'h71, 7'd1, 8'h04);
    dev_wr(7'h71, 7'd1, 8'h06);
    chk8("pll_reacquire_trigger pulses", 8'h01, 8'(pll_reacquire_trigger_n));
    dev_rd(7'h71, 7'd1, 8'h04);
    $display("test sync and pll_reacquire_trigger done");
    dev_wr(7'h1c, 7'd1, 8'h02);
    chk1("count mode", 1'b1, mode_o);
    dev_wr(7'h70, 7'd1, 8'h01);
    chk8("internal fire", 8'h01, 8'(fire_n));
    dev_rd(7'h70, 7'd1, 8'h00);
    dev_wr(7'h1c, 7'd1, 8'h03);
    dev_wr(7'h70, 7'd1, 8'h01);
    chk8("armed no fire", 8'h01, 8'(fire_n));
    ext_trig <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk8("external fire", 8'h02, 8'(fire_n));
    $display("test pulse start done");
    close_out();
  end
endmodule : tb
`default_nettype wire
